/* File: hw/mpc_train_pkg.sv */
package mpc_train_pkg;

    // ==========
    // operand codes, full seven bits with the top bit set
    // ==========
    localparam logic [6:0] OP_BUF_READ      = 7'h41;
    localparam logic [6:0] OP_PATTERN_READ  = 7'h43;
    localparam logic [6:0] OP_BUF_WRITE     = 7'h47;
    localparam logic [6:0] OP_OSC_START     = 7'h49;
    localparam logic [6:0] OP_OSC_STOP      = 7'h4d;
    localparam logic [6:0] OP_CAL_BEGIN     = 7'h4f;
    localparam logic [6:0] OP_CAL_APPLY     = 7'h51;

    // ==========
    // training buffer shape
    // ==========
    localparam int         BURST_BEATS      = 16;
    localparam int         BUF_ENTRIES      = 5;
    localparam int         PTR_W            = 3;
    localparam int         BEAT_W           = 4;
    localparam int         PEND_W           = 3;
    localparam int         PATTERN_HALF     = 8;
    localparam int         DMI_W            = 2;
    localparam logic [PTR_W-1:0]  PTR_LAST  = 3'h4;
    localparam logic [BEAT_W-1:0] BEAT_LAST = 4'hf;
    localparam logic [PTR_W-1:0]  PTR_RESET = 3'h0;

    // ==========
    // pending training transfer kinds
    // ==========
    typedef enum logic [1:0] {
        XFER_NONE,
        XFER_BUF_WRITE,
        XFER_BUF_READ,
        XFER_PATTERN
    } xfer_kind_t;

endpackage : mpc_train_pkg

/* File: hw/lpddr4_mpc_training_fifo.sv */
// Overview of operation
// [RULE1] top bit low: no-op; 41h buffer read; 43h pattern read
// [RULE2] 47h buffer write; 49h oscillator start
// [RULE3] 4Dh oscillator stop; 4Fh cal begin; 51h cal apply
// [RULE4] reserved codes change no state
// [RULE5] buffer transfers are always sixteen beats
// [RULE6] CAS-2 directly follows a transferring training command
// [RULE7] CAS-2 operand bits are low
// [RULE8] buffer writes taken in any bank or refresh state
// [RULE9] buffer writes may run back to back
// [RULE10] buffer writes use the write latency
// [RULE11] five entries in turn; sixth write overwrites the first
// [RULE12] unwritten entries are undefined
// [RULE13] read pointer advances per read, wraps after five
// [RULE14] unwritten entry reads are undefined
// [RULE15] buffer reads follow writes with no disturbing command
// [RULE16] cke fall, writes, reads, pattern and mode reads disturb pointers
// [RULE17] write-to-training-write delay kept after a write
// [RULE18] training read-to-read delay kept before a read
// [RULE19] buffer reads use the read latency
// [RULE20] mask pins driven on buffer reads when any mode needs them
// [RULE21] buffer reads may run back to back, data intact
// [RULE22] top bit on the first edge, the rest on the second
// [RULE23] latency counts from the CAS-2 second edge
`timescale 1ns/1ps

// ==========
// write data fifo
// ==========
module beat_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_i,
    input  wire logic             srst_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
            $error("beat_fifo: depth must be a power of two of at least 2");
        end
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr_ptr;
        logic [AW-1:0]               rd_ptr;
        logic [AW:0]                 count;
    } fifo_state_t;

    fifo_state_t st_reg;
    fifo_state_t st_next;
    logic        push;
    logic        pop;

    assign in_ready_o  = (st_reg.count != DEPTH[AW:0]);
    assign out_valid_o = (st_reg.count != '0);
    assign out_data_o  = st_reg.mem[st_reg.rd_ptr];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_comb begin
        st_next = st_reg;
        if (push) begin
            st_next.mem[st_reg.wr_ptr] = in_data_i;
            st_next.wr_ptr = st_reg.wr_ptr + 1'b1;
        end
        if (pop) begin
            st_next.rd_ptr = st_reg.rd_ptr + 1'b1;
        end
        if (push && !pop) begin
            st_next.count = st_reg.count + 1'b1;
        end else if (pop && !push) begin
            st_next.count = st_reg.count - 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
endmodule : beat_fifo

// ==========
// command decode, training buffer and data engines
// ==========
module lpddr4_mpc_training_fifo #(
    parameter int DQ_W    = 16,
    parameter int LAT_MAX = 64,
    parameter int FIFO_D  = 16
) (
    input  wire logic              clk_i,
    input  wire logic              srst_i,
    input  wire logic              cke_i,
    input  wire logic              mpc_edge1_i,
    input  wire logic              op_top_i,
    input  wire logic              mpc_edge2_i,
    input  wire logic [5:0]        op_low_i,
    input  wire logic              cas2_edge2_i,
    input  wire logic              norm_write_i,
    input  wire logic              mask_write_i,
    input  wire logic              norm_read_i,
    input  wire logic              mode_read_i,
    input  wire logic [5:0]        write_lat_i,
    input  wire logic [5:0]        read_lat_i,
    input  wire logic              wr_inv_en_i,
    input  wire logic              rd_inv_en_i,
    input  wire logic              mask_en_i,
    input  wire logic [7:0]        pattern_lo_i,
    input  wire logic [7:0]        pattern_hi_i,
    input  wire logic [DQ_W-1:0]   invert_mask_i,
    input  wire logic              wdata_valid_i,
    output logic                   wdata_ready_o,
    input  wire logic [DQ_W-1:0]   wdata_i,
    input  wire logic [1:0]        wdmi_i,
    output logic                   rdata_valid_o,
    output logic      [DQ_W-1:0]   rdata_o,
    output logic      [1:0]        rdmi_o,
    output logic                   rdmi_oe_o,
    output logic                   osc_start_o,
    output logic                   osc_stop_o,
    output logic                   impedance_cal_begin_o,
    output logic                   impedance_cal_apply_o
);
    localparam int W    = DQ_W + mpc_train_pkg::DMI_W;
    localparam int NB   = mpc_train_pkg::BURST_BEATS;
    localparam int NE   = mpc_train_pkg::BUF_ENTRIES;
    localparam int PW   = mpc_train_pkg::PTR_W;
    localparam int BW   = mpc_train_pkg::BEAT_W;
    localparam int QW   = mpc_train_pkg::PEND_W;
    localparam int HALF = mpc_train_pkg::PATTERN_HALF;

    initial begin
        if (DQ_W < 1 || LAT_MAX < 2 || LAT_MAX > 64) begin
            $error("lpddr4_mpc_training_fifo: unsupported parameters");
        end
    end

    typedef struct packed {
        logic [2:0]                   cke_sync;
        logic                         cke_stable;
        logic                         op_top;
        mpc_train_pkg::xfer_kind_t    await_cas2;
        logic [LAT_MAX-1:0]           wr_line;
        logic [LAT_MAX-1:0]           rd_line;
        logic [LAT_MAX-1:0]           pat_line;
        logic [QW-1:0]                wr_pend;
        logic [QW-1:0]                rd_pend;
        logic                         rd_active;
        logic                         rd_is_pat;
        logic [PW-1:0]                wptr;
        logic [PW-1:0]                rptr;
        logic [BW-1:0]                wbeat;
        logic [BW-1:0]                rbeat;
        logic [NE-1:0]                written;
        logic [NE-1:0][NB-1:0][W-1:0] mem;
        logic                         rvalid;
        logic [DQ_W-1:0]              rdata;
        logic [1:0]                   rdmi;
        logic                         rdmi_oe;
        logic                         osc_start;
        logic                         osc_stop;
        logic                         cal_begin;
        logic                         cal_apply;
    } core_state_t;

    core_state_t    st_reg;
    core_state_t    st_next;
    logic           fifo_valid;
    logic           fifo_ready;
    logic [W-1:0]   fifo_data;

    // entries advance modulo five
    function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
        ptr_inc = (p == mpc_train_pkg::PTR_LAST) ? mpc_train_pkg::PTR_RESET
                                                 : p + 1'b1;
    endfunction : ptr_inc

    // fires when the shifted command reaches the programmed latency
    function automatic logic lat_tap(input logic [LAT_MAX-1:0] line,
                                     input logic               now,
                                     input logic [5:0]         lat);
        if (lat == 6'h00) begin
            lat_tap = now;
        end else begin
            lat_tap = line[lat - 6'h01];
        end
    endfunction : lat_tap

    beat_fifo #(
        .WIDTH (W),
        .DEPTH (FIFO_D)
    ) u_wfifo (
        .clk_i       (clk_i),
        .srst_i      (srst_i),
        .in_valid_i  (wdata_valid_i),
        .in_ready_o  (wdata_ready_o),
        .in_data_i   ({wdmi_i, wdata_i}),
        .out_valid_o (fifo_valid),
        .out_ready_i (fifo_ready),
        .out_data_o  (fifo_data)
    );

    // the buffer drains the fifo only while a write burst is due
    assign fifo_ready = (st_reg.wr_pend != '0);

    always_comb begin
        logic [6:0] op;
        logic       disturb;
        logic       cke_fall;
        logic       cas_wr;
        logic       cas_rd;
        logic       cas_pat;
        logic       wr_due;
        logic       rd_due;
        logic       pat_due;
        logic       wr_done;
        logic       rd_start;
        logic       pat_bit;
        logic       any_inv;
        op       = {st_reg.op_top, op_low_i};
        disturb  = 1'b0;
        cke_fall = 1'b0;
        cas_wr   = 1'b0;
        cas_rd   = 1'b0;
        cas_pat  = 1'b0;
        wr_done  = 1'b0;
        rd_start = 1'b0;
        pat_bit  = 1'b0;
        any_inv  = wr_inv_en_i || rd_inv_en_i || mask_en_i;
        st_next  = st_reg;

        st_next.osc_start = 1'b0;
        st_next.osc_stop  = 1'b0;
        st_next.cal_begin = 1'b0;
        st_next.cal_apply = 1'b0;

        // ==========
        // clock enable: three stages, change taken when last two agree
        // ==========
        st_next.cke_sync = {st_reg.cke_sync[1:0], cke_i};
        if (st_reg.cke_sync[1] == st_reg.cke_sync[2]) begin
            st_next.cke_stable = st_reg.cke_sync[2];
            cke_fall = st_reg.cke_stable && !st_reg.cke_sync[2];
        end

        // ==========
        // operand capture and decode
        // ==========
        if (mpc_edge1_i) begin
            st_next.op_top = op_top_i;                      // [RULE22]
        end
        if (mpc_edge2_i && st_reg.op_top) begin             // [RULE1]
            case (op)                                       // [RULE22]
                mpc_train_pkg::OP_BUF_READ: begin           // [RULE1]
                    st_next.await_cas2 = mpc_train_pkg::XFER_BUF_READ;
                end
                mpc_train_pkg::OP_PATTERN_READ: begin       // [RULE1]
                    st_next.await_cas2 = mpc_train_pkg::XFER_PATTERN;
                    disturb = 1'b1;                         // [RULE16]
                end
                mpc_train_pkg::OP_BUF_WRITE: begin          // [RULE2]
                    st_next.await_cas2 = mpc_train_pkg::XFER_BUF_WRITE;
                end
                mpc_train_pkg::OP_OSC_START: begin          // [RULE2]
                    st_next.osc_start = 1'b1;
                end
                mpc_train_pkg::OP_OSC_STOP: begin           // [RULE3]
                    st_next.osc_stop = 1'b1;
                end
                mpc_train_pkg::OP_CAL_BEGIN: begin          // [RULE3]
                    st_next.cal_begin = 1'b1;
                end
                mpc_train_pkg::OP_CAL_APPLY: begin          // [RULE3]
                    st_next.cal_apply = 1'b1;
                end
                default: begin
                    // reserved code: nothing changes          [RULE4]
                end
            endcase
        end

        // ==========
        // CAS-2 launches the transfer chosen by the preceding command
        // ==========
        if (cas2_edge2_i) begin                             // [RULE6]
            cas_wr  = (st_reg.await_cas2 == mpc_train_pkg::XFER_BUF_WRITE);
            cas_rd  = (st_reg.await_cas2 == mpc_train_pkg::XFER_BUF_READ);
            cas_pat = (st_reg.await_cas2 == mpc_train_pkg::XFER_PATTERN);
            st_next.await_cas2 = mpc_train_pkg::XFER_NONE;
        end

        // latency lines count from the CAS-2 second edge       [RULE23]
        st_next.wr_line  = {st_reg.wr_line[LAT_MAX-2:0], cas_wr};
        st_next.rd_line  = {st_reg.rd_line[LAT_MAX-2:0], cas_rd};
        st_next.pat_line = {st_reg.pat_line[LAT_MAX-2:0], cas_pat};
        wr_due  = lat_tap(st_reg.wr_line, cas_wr, write_lat_i);  // [RULE10]
        rd_due  = lat_tap(st_reg.rd_line, cas_rd, read_lat_i);   // [RULE19]
        pat_due = lat_tap(st_reg.pat_line, cas_pat, read_lat_i); // [RULE19]

        // ==========
        // write engine: sixteen beats per burst, regardless of mode state
        // ==========
        if (fifo_valid && fifo_ready) begin                 // [RULE8]
            st_next.mem[st_reg.wptr][st_reg.wbeat] = fifo_data;
            st_next.wbeat = st_reg.wbeat + 1'b1;            // [RULE5]
            if (st_reg.wbeat == mpc_train_pkg::BEAT_LAST) begin
                wr_done = 1'b1;
                st_next.written[st_reg.wptr] = 1'b1;        // [RULE12]
                st_next.wptr = ptr_inc(st_reg.wptr);        // [RULE11]
            end
        end
        // queued bursts keep seamless writes from being lost  [RULE9]
        st_next.wr_pend = st_reg.wr_pend + QW'(wr_due) - QW'(wr_done);

        // ==========
        // read engine: buffer entries or the calibration pattern
        // ==========
        st_next.rvalid  = 1'b0;
        st_next.rdmi_oe = 1'b0;
        st_next.rdata   = '0;
        st_next.rdmi    = '0;
        st_next.rd_pend = st_reg.rd_pend + QW'(rd_due || pat_due);
        if (pat_due) begin
            st_next.rd_is_pat = 1'b1;
        end else if (rd_due) begin
            st_next.rd_is_pat = 1'b0;
        end
        if (!st_reg.rd_active && st_reg.rd_pend != '0) begin
            rd_start = 1'b1;
        end
        if (rd_start) begin
            st_next.rd_active = 1'b1;
            st_next.rbeat     = '0;
            st_next.rd_pend   = st_next.rd_pend - 1'b1;
        end
        if (st_reg.rd_active) begin
            st_next.rvalid = 1'b1;
            st_next.rbeat  = st_reg.rbeat + 1'b1;           // [RULE5]
            if (st_reg.rd_is_pat) begin
                if (st_reg.rbeat < BW'(HALF)) begin
                    pat_bit = pattern_lo_i[st_reg.rbeat[2:0]];
                end else begin
                    pat_bit = pattern_hi_i[st_reg.rbeat[2:0]];
                end
                st_next.rdata   = {DQ_W{pat_bit}} ^ invert_mask_i;
                st_next.rdmi    = {2{pat_bit}};
                st_next.rdmi_oe = 1'b1;
            end else begin
                if (st_reg.written[st_reg.rptr]) begin      // [RULE14]
                    {st_next.rdmi, st_next.rdata} =
                        st_reg.mem[st_reg.rptr][st_reg.rbeat];
                end
                st_next.rdmi_oe = any_inv;                  // [RULE20]
                if (!any_inv) begin
                    st_next.rdmi = '0;
                end
            end
            if (st_reg.rbeat == mpc_train_pkg::BEAT_LAST) begin
                if (!st_reg.rd_is_pat) begin
                    st_next.rptr = ptr_inc(st_reg.rptr);    // [RULE13]
                end
                // a queued burst follows with no idle beat    [RULE21]
                if (st_reg.rd_pend != '0) begin
                    st_next.rbeat   = '0;
                    st_next.rd_pend = st_next.rd_pend - 1'b1;
                end else begin
                    st_next.rd_active = 1'b0;
                end
            end
        end

        // ==========
        // pointer disturbance
        // ==========
        disturb = disturb || cke_fall || norm_write_i || mask_write_i
               || norm_read_i || mode_read_i;               // [RULE16]
        if (disturb) begin
            st_next.wptr    = mpc_train_pkg::PTR_RESET;     // [RULE16]
            st_next.rptr    = mpc_train_pkg::PTR_RESET;
            st_next.written = '0;                           // [RULE14]
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign rdata_valid_o         = st_reg.rvalid;
    assign rdata_o               = st_reg.rdata;
    assign rdmi_o                = st_reg.rdmi;
    assign rdmi_oe_o             = st_reg.rdmi_oe;
    assign osc_start_o           = st_reg.osc_start;
    assign osc_stop_o            = st_reg.osc_stop;
    assign impedance_cal_begin_o = st_reg.cal_begin;
    assign impedance_cal_apply_o = st_reg.cal_apply;
endmodule : lpddr4_mpc_training_fifo

/* File: tb/lpddr4_mpc_training_fifo_asserts.sv */
`timescale 1ns/1ps
// ==========
// port checks for the training block
module lpddr4_mpc_training_fifo_asserts (
    input  wire logic       clk_i,
    input  wire logic       srst_i,
    input  wire logic       mpc_edge1_i,
    input  wire logic       op_top_i,
    input  wire logic       mpc_edge2_i,
    input  wire logic [5:0] op_low_i,
    input  wire logic       wr_inv_en_i,
    input  wire logic       rd_inv_en_i,
    input  wire logic       mask_en_i,
    input  wire logic       rdata_valid_o,
    input  wire logic       rdmi_oe_o,
    input  wire logic       osc_start_o,
    input  wire logic       osc_stop_o,
    input  wire logic       impedance_cal_begin_o,
    input  wire logic       impedance_cal_apply_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);
    logic [7:0] run_reg;
    logic       any_pulse;
    assign any_pulse = osc_start_o | osc_stop_o
                     | impedance_cal_begin_o | impedance_cal_apply_o;
    // length of the current run of read beats
    always_ff @(posedge clk_i) begin
        run_reg <= (srst_i || !rdata_valid_o) ? 8'h00 : run_reg + 8'h01;
    end
    property code_p(logic [5:0] code, logic out);
        mpc_edge2_i && op_low_i == code
            && $past(mpc_edge1_i && op_top_i) |=> out;
    endproperty
    osc_start_a: assert property (code_p(6'h09, osc_start_o))
        else $error("oscillator start pulse missing");
    osc_stop_a: assert property (code_p(6'h0d, osc_stop_o))
        else $error("oscillator stop pulse missing");
    cal_begin_a: assert property (code_p(6'h0f, impedance_cal_begin_o))
        else $error("calibration begin pulse missing");
    cal_apply_a: assert property (code_p(6'h11, impedance_cal_apply_o))
        else $error("calibration apply pulse missing");
    nop_quiet_a: assert property (mpc_edge2_i
        && $past(mpc_edge1_i && !op_top_i) |=> !any_pulse)
        else $error("no-op produced a pulse");
    pulse_cause_a: assert property (any_pulse |-> $past(mpc_edge2_i)
        && $past(op_top_i, 2)) else $error("pulse without command");
    pulse_width_a: assert property ($rose(any_pulse) |=> !any_pulse)
        else $error("pulse longer than one cycle");
    burst_len_a: assert property ($fell(rdata_valid_o) |->
        run_reg[3:0] == 4'h0 && run_reg != 8'h00)
        else $error("read run not whole bursts");
    dmi_drive_a: assert property (rdata_valid_o && (wr_inv_en_i
        || rd_inv_en_i || mask_en_i) |-> rdmi_oe_o)
        else $error("mask pins not driven");
    cover property ($fell(rdata_valid_o));
    cover property (impedance_cal_apply_o);
    cover property (rdata_valid_o && rdmi_oe_o);
endmodule : lpddr4_mpc_training_fifo_asserts

/* File: tb/ctrl_model.sv */
`timescale 1ns/1ps
// ==========
// controller side: command pulses and write beats
module ctrl_model (
    input  wire logic        clk_i,
    input  wire logic        wdata_ready_i,
    output logic             cke_o,
    output logic             mpc_edge1_o,
    output logic             op_top_o,
    output logic             mpc_edge2_o,
    output logic [5:0]       op_low_o,
    output logic             cas2_edge2_o,
    output logic             norm_read_o,
    output logic             wdata_valid_o,
    output logic [15:0]      wdata_o,
    output logic [1:0]       wdmi_o
);
    logic ok;
    initial begin
        {cke_o, mpc_edge1_o, mpc_edge2_o, cas2_edge2_o} = 4'h8;
        {norm_read_o, wdata_valid_o, op_top_o} = 3'h0;
        {op_low_o, wdata_o, wdmi_o} = 24'h000000;
    end
    task automatic mpc(input logic [6:0] op);
        @(posedge clk_i);
        mpc_edge1_o <= 1'b1;
        op_top_o <= op[6];
        @(posedge clk_i);
        mpc_edge1_o <= 1'b0;
        op_top_o <= ~op[6];
        mpc_edge2_o <= 1'b1;
        op_low_o <= op[5:0];
        @(posedge clk_i);
        mpc_edge2_o <= 1'b0;
        op_low_o <= ~op[5:0];
    endtask : mpc
    // called right after mpc, no gap; operand bits stay at the inverse of the last MPC operand
    task automatic cas2();
        cas2_edge2_o <= 1'b1;
        @(posedge clk_i);
        cas2_edge2_o <= 1'b0;
    endtask : cas2
    // caller leaves a long gap after an ordinary read
    task automatic pulse_read();
        @(posedge clk_i);
        norm_read_o <= 1'b1;
        @(posedge clk_i);
        norm_read_o <= 1'b0;
    endtask : pulse_read
    task automatic cke_drop();
        @(posedge clk_i);
        cke_o <= 1'b0;
        repeat (4) @(posedge clk_i);
        cke_o <= 1'b1;
        repeat (4) @(posedge clk_i);
    endtask : cke_drop
    // one beat; held until ready seen at a falling edge
    task automatic push(input logic [15:0] d, input logic [1:0] m);
        @(posedge clk_i);
        wdata_valid_o <= 1'b1;
        wdata_o <= d;
        wdmi_o <= m;
        do begin
            @(negedge clk_i);
            ok = wdata_ready_i;
            @(posedge clk_i);
        end while (!ok);
        wdata_valid_o <= 1'b0;
        wdata_o <= ~d;
        wdmi_o <= ~m;
    endtask : push
endmodule : ctrl_model

/* File: tb/lpddr4_mpc_training_fifo_bench.sv */
`timescale 1ns/1ps
// ==========
// scenarios for the training block
module lpddr4_mpc_training_fifo_bench;
    localparam logic [5:0] WL = 6'h03;
    localparam logic [5:0] RL = 6'h05;
    logic clk_i = 1'b0, srst_i = 1'b1, cke_i, mpc_edge1_i, op_top_i;
    logic mpc_edge2_i, cas2_edge2_i, norm_read_i, wdata_valid_i, mode_read_i;
    logic [5:0] op_low_i, write_lat_i = 6'h00, read_lat_i = 6'h00;
    logic wr_inv_en_i = 1'b0, rd_inv_en_i = 1'b0, mask_en_i = 1'b0;
    logic [7:0] pattern_lo_i = 8'ha5, pattern_hi_i = 8'h3c;
    logic [15:0] invert_mask_i = 16'h00ff, wdata_i, rdata_o;
    logic [1:0] wdmi_i, rdmi_o;
    logic wdata_ready_o, rdata_valid_o, rdmi_oe_o, osc_start_o;
    logic osc_stop_o, impedance_cal_begin_o, impedance_cal_apply_o;
    int bad_count = 0, checks = 0;
    always #2 clk_i = ~clk_i;
    lpddr4_mpc_training_fifo u_lpddr4_mpc_training_fifo (.clk_i, .srst_i,
        .cke_i, .mpc_edge1_i, .op_top_i, .mpc_edge2_i, .op_low_i,
        .cas2_edge2_i, .norm_write_i(1'b0), .mask_write_i(1'b0),
        .norm_read_i, .mode_read_i, .write_lat_i, .read_lat_i,
        .wr_inv_en_i, .rd_inv_en_i, .mask_en_i, .pattern_lo_i,
        .pattern_hi_i, .invert_mask_i, .wdata_valid_i, .wdata_ready_o,
        .wdata_i, .wdmi_i, .rdata_valid_o, .rdata_o, .rdmi_o, .rdmi_oe_o,
        .osc_start_o, .osc_stop_o, .impedance_cal_begin_o,
        .impedance_cal_apply_o);
    ctrl_model u_ctrl_model (.clk_i, .wdata_ready_i(wdata_ready_o),
        .cke_o(cke_i), .mpc_edge1_o(mpc_edge1_i), .op_top_o(op_top_i),
        .mpc_edge2_o(mpc_edge2_i), .op_low_o(op_low_i),
        .cas2_edge2_o(cas2_edge2_i), .norm_read_o(norm_read_i),
        .wdata_valid_o(wdata_valid_i), .wdata_o(wdata_i), .wdmi_o(wdmi_i));
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : final_report
    task automatic chk(input string what, input logic [18:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s exp %h seen %h", what, exp, seen);
        end
    endtask : chk
    // expected {oe, dmi, data}: 0 unwritten, 1 buffer entry, 2 pattern
    function automatic logic [18:0] expv(input int mode, r, k);
        logic b, en;
        int t;
        b = (k < 8) ? pattern_lo_i[k] : pattern_hi_i[k-8];
        t = (r % 5 == 0) ? 5 : r % 5;
        en = wr_inv_en_i | rd_inv_en_i | mask_en_i;
        if (mode == 2) return {1'b1, {2{b}}, {16{b}} ^ invert_mask_i};
        if (mode == 0) return {en, 18'h00000};
        return {en, en ? 2'(k) : 2'h0, 4'ha, 4'(t), 4'h5, 4'(k)};
    endfunction : expv
    task automatic write_burst(input int w);
        for (int k = 0; k < 16; k++)
            u_ctrl_model.push({4'ha, 4'(w), 4'h5, 4'(k)}, 2'(k));
        @(negedge clk_i);
        chk("full", 19'(wdata_ready_o), 19'h0);
        u_ctrl_model.mpc(7'h47);
        u_ctrl_model.cas2();
        repeat (WL + 17) @(posedge clk_i);
        @(negedge clk_i);
        chk("drained", 19'(wdata_ready_o), 19'h1);
    endtask : write_burst
    task automatic rd_many(input logic [6:0] op, input int r0, n, mode);
        u_ctrl_model.mpc(op);
        u_ctrl_model.cas2();
        fork
            for (int i = 1; i < n; i++) begin
                repeat (4) @(posedge clk_i);
                u_ctrl_model.mpc(op);
                u_ctrl_model.cas2();
            end
            begin
                repeat (RL + 2) @(negedge clk_i);
                chk("early", 19'(rdata_valid_o), 19'h0);
                for (int j = 0; j < n * 16; j++) begin
                    @(negedge clk_i);
                    chk("valid", 19'(rdata_valid_o), 19'h1);
                    chk("beat", {rdmi_oe_o, rdmi_o, rdata_o},
                        expv(mode, r0 + j / 16, j % 16));
                end
            end
        join
    endtask : rd_many
    task automatic t_decode();
        logic [6:0] op [7] = '{7'h49, 7'h4d, 7'h4f, 7'h51,
                               7'h0f, 7'h45, 7'h4b};
        for (int i = 0; i < 7; i++) begin
            u_ctrl_model.mpc(op[i]);
            @(negedge clk_i);
            chk("pulse", 19'({osc_start_o, osc_stop_o,
                impedance_cal_begin_o, impedance_cal_apply_o}),
                19'(i < 4 ? 4'h8 >> i : 4'h0));
        end
    endtask : t_decode
    task automatic t_wrap();
        mask_en_i <= 1'b1;
        for (int w = 0; w < 6; w++) write_burst(w);
        rd_many(7'h41, 0, 6, 1);
    endtask : t_wrap
    // pattern read, ordinary read, clock enable drop, reserved code and no-op
    task automatic t_disturb();
        for (int d = 0; d < 4; d++) begin
            {wr_inv_en_i, rd_inv_en_i, mask_en_i} <= 3'h4 >> d;
            if (d == 3) begin
                @(posedge clk_i);
                mode_read_i <= 1'b1;
                @(posedge clk_i);
                mode_read_i <= 1'b0;
            end
            write_burst(1);
            case (d)
                0: rd_many(7'h43, 0, 1, 2);
                1: u_ctrl_model.pulse_read();
                2: u_ctrl_model.cke_drop();
                default: begin
                    u_ctrl_model.mpc(7'h45);
                    u_ctrl_model.mpc(7'h0f);
                end
            endcase
            repeat (40) @(posedge clk_i);
            rd_many(7'h41, 1, 1, d == 3);
        end
    endtask : t_disturb
    initial begin
        repeat (5) @(posedge clk_i);
        srst_i <= 1'b0;
        mode_read_i <= 1'b0;
        write_lat_i <= WL;
        read_lat_i <= RL;
        t_decode();
        t_wrap();
        t_disturb();
        final_report();
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        bad_count++;
        final_report();
    end
endmodule : lpddr4_mpc_training_fifo_bench
bind lpddr4_mpc_training_fifo lpddr4_mpc_training_fifo_asserts u_chk (
    .clk_i, .srst_i, .mpc_edge1_i, .op_top_i, .mpc_edge2_i, .op_low_i,
    .wr_inv_en_i, .rd_inv_en_i, .mask_en_i, .rdata_valid_o, .rdmi_oe_o,
    .osc_start_o, .osc_stop_o, .impedance_cal_begin_o,
    .impedance_cal_apply_o);
